// >>> inc/ramg_pkg.sv
// Constants, types and helpers shared by the RAM port and its DMA arbiter.
// Function
// - RAM is 8, 12 or 16 Kbytes, first word at address 0x20000000.
// - RAM is a slave on the system bus, reachable by processor and debugger.
// - Fetches and data accesses of byte, half-word and word size are served.
// - RAM is 32 bits wide and answers with zero wait states normally.
// - In the fast clock mode every access other than a refused write gets two wait states by itself.
// - Six DMA channels: MAC, ADC, receive and transmit of two serial units.
// - Fixed DMA priority: ADC, S2 Rx, S2 Tx, MAC, S1 Rx, S1 Tx; CPU served.
// - RAM splits into equal blocks; a set map bit write-protects its block.
// - Protection block is 32 bytes on the 8K variant, 64 bytes otherwise.
// - A user-mode write into a protected block gets an error response.
// - System-mode writes always succeed; reads succeed in either mode.
// - An enable bit extends protection checking to DMA writes.
// - A DMA write into a protected block raises the management interrupt.
// - Fault address and channel id are captured with the interrupt.
// - Only channels that write RAM can raise the DMA protection interrupt.
package ramg_pkg;

  localparam logic [31:0] RAM_BASE   = 32'h2000_0000;
  localparam int          RAM_KB_DEF = 16;
  localparam int          IDX_W      = 12;
  localparam int          MAP_W      = 8;
  localparam int          MAP_BITS   = 256;
  localparam int          NUM_CH     = 6;
  localparam int          CH_W       = 3;
  localparam int          WAIT_FAST  = 2;
  localparam int          SHIFT_SMALL = 5;
  localparam int          SHIFT_LARGE = 6;

  // Channel identifiers, highest priority first.
  localparam logic [CH_W-1:0] CH_ADC   = 3'h0;
  localparam logic [CH_W-1:0] CH_S2_RX = 3'h1;
  localparam logic [CH_W-1:0] CH_S2_TX = 3'h2;
  localparam logic [CH_W-1:0] CH_MAC   = 3'h3;
  localparam logic [CH_W-1:0] CH_S1_RX = 3'h4;
  localparam logic [CH_W-1:0] CH_S1_TX = 3'h5;

  // Channels allowed to write RAM; transmit channels only read.
  localparam logic [NUM_CH-1:0] CH_WR_CAP = 6'h1B;

  // Reset values of the fault capture.
  localparam logic [31:0]     FAULT_ADDR_RST = 32'h0000_0000;
  localparam logic [CH_W-1:0] FAULT_ID_RST   = 3'h0;

  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ramg_dma_req_t;

  typedef struct packed {
    logic [31:0]     addr;
    logic [CH_W-1:0] id;
  } ramg_fault_t;

  typedef enum logic [1:0] {DP_IDLE, DP_WAIT, DP_ERR1, DP_ERR2} ramg_dp_t;

  // Block size exponent for a given RAM size in Kbytes.
  function automatic int ramg_blk_shift(input int kb);
    return (kb == 8) ? SHIFT_SMALL : SHIFT_LARGE;
  endfunction

  // Byte lanes touched by an access of the given size and low address.
  function automatic logic [3:0] ramg_strb(input logic [2:0] size,
                                           input logic [1:0] a);
    logic [3:0] s;
    case (size)
      3'h0:    s = 4'h1 << a;
      3'h1:    s = a[1] ? 4'hC : 4'h3;
      default: s = 4'hF;
    endcase
    return s;
  endfunction

  // Merges new bytes into an old word under a lane mask.
  function automatic logic [31:0] ramg_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

endpackage

// >>> rtl/ramg_arb.sv
// Fixed-priority selector for the DMA channels competing for a RAM slot.
`timescale 1ns/10ps
module ramg_arb
  import ramg_pkg::*;
#(
  parameter int N = NUM_CH
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0]      hold_off,
  input  wire logic              slot_free,
  output logic      [N-1:0]      sel,
  output logic      [CH_W-1:0]   sel_id,
  output logic                   go
);

  logic [N-1:0] elig;
  logic [N:0]   taken;

  initial begin
    if (N < 1 || N > (1 << CH_W)) begin
      $error("ramg_arb: channel count out of range");
    end
  end

  // A channel just granted sits out one cycle so its request can drop.
  assign elig     = req & ~hold_off & {N{slot_free}};
  assign taken[0] = 1'b0;

  // Lowest index wins; each stage is blocked by any eligible stage above it.
  for (genvar i = 0; i < N; i++) begin : g_prio
    assign sel[i]     = elig[i] & ~taken[i];
    assign taken[i+1] = taken[i] | elig[i];
  end

  assign go = taken[N];

  // Encodes the one-hot selection into a channel identifier.
  always_comb begin
    sel_id = '0;
    for (int i = 0; i < N; i++) begin
      if (sel[i]) begin
        sel_id = CH_W'(i);
      end
    end
  end

  a_prio_fixed: assert property (@(posedge ref_clk) disable iff (srst)
    go |-> $onehot(sel) && ((elig & (sel - 1'b1)) == '0))
    else $error("DMA grant skipped a higher priority channel");

endmodule

// >>> rtl/ramg_ram_port.sv
// System-bus RAM port with DMA arbitration and block write protection.
`timescale 1ns/10ps
module ramg_ram_port
  import ramg_pkg::*;
#(
  parameter int RAM_KB = RAM_KB_DEF
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [3:0]                 hprot,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       fast_clk_mode,
  input  wire logic                       dma_chk_en,
  input  wire logic [MAP_BITS-1:0]        prot_map,
  input  wire logic [NUM_CH-1:0]          dma_req_vld,
  input  wire ramg_dma_req_t [NUM_CH-1:0] dma_req,
  output logic      [NUM_CH-1:0]          dma_gnt,
  output logic      [31:0]                dma_rdata,
  input  wire logic                       fault_clr,
  output logic                            fault_irq,
  output ramg_fault_t                     fault_info
);

  localparam int DEPTH     = RAM_KB * 256;
  localparam int BLK_SHIFT = ramg_blk_shift(RAM_KB);

  initial begin
    if (RAM_KB != 8 && RAM_KB != 12 && RAM_KB != 16) begin
      $error("ramg_ram_port: RAM size must be 8, 12 or 16 Kbytes");
    end
  end

  // Word storage and bus-facing state.
  logic [31:0]     mem_reg [DEPTH];
  ramg_dp_t        dp_st_reg,     dp_st_next;
  logic            wait_cnt_reg,  wait_cnt_next;
  logic            wr_pend_reg,   wr_pend_next;
  logic [IDX_W-1:0] dp_idx_reg,   dp_idx_next;
  logic [3:0]      dp_strb_reg,   dp_strb_next;
  logic [31:0]     hrdata_reg,    hrdata_next;
  logic            hready_reg,    hready_next;
  logic            hresp_reg,     hresp_next;
  logic [NUM_CH-1:0] gnt_reg,     gnt_next;
  logic [31:0]     drd_reg,       drd_next;
  logic            irq_reg,       irq_next;
  ramg_fault_t     fault_reg,     fault_next;

  // Write port, shared by the processor and DMA.
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wr_data;

  // Address decode of the bus and DMA requests.
  logic [31:0]      cpu_off, dma_off, cpu_blk, dma_blk;
  logic [IDX_W-1:0] cpu_idx, dma_idx;
  logic             acc, cpu_rd_now, cpu_prot, cpu_block, slot_free;
  logic [NUM_CH-1:0] dma_sel;
  logic [CH_W-1:0]  dma_id;
  logic             dma_go, dma_prot, dma_wr, dma_fault, dma_wr_en;
  ramg_dma_req_t    dma_cur;

  // Offsets from the RAM base give word and protection-block indices.
  assign cpu_off = haddr - RAM_BASE;
  assign dma_off = dma_cur.addr - RAM_BASE;
  assign cpu_idx = cpu_off[IDX_W+1:2];
  assign dma_idx = dma_off[IDX_W+1:2];
  assign cpu_blk = cpu_off >> BLK_SHIFT;
  assign dma_blk = dma_off >> BLK_SHIFT;
  assign cpu_prot = prot_map[cpu_blk[MAP_W-1:0]];
  assign dma_prot = prot_map[dma_blk[MAP_W-1:0]];

  // Address phase taken from the bus; user writes to set blocks are refused.
  assign acc        = hsel && htrans[1] && hready;
  assign cpu_block  = hwrite && !hprot[1] && cpu_prot;
  assign cpu_rd_now = acc && !hwrite;
  assign slot_free  = !cpu_rd_now && !wr_pend_reg;

  ramg_arb #(.N(NUM_CH)) u_arb (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .req       (dma_req_vld),
    .hold_off  (gnt_reg),
    .slot_free (slot_free),
    .sel       (dma_sel),
    .sel_id    (dma_id),
    .go        (dma_go)
  );

  // DMA write screening; transmit channels never write or fault.
  assign dma_cur   = dma_req[dma_id];
  assign dma_wr    = dma_go && dma_cur.write && CH_WR_CAP[dma_id];
  assign dma_fault = dma_wr && dma_chk_en && dma_prot;
  assign dma_wr_en = dma_wr && !dma_fault;

  // Selects the single write of this cycle; the slots never overlap.
  always_comb begin
    wr_en   = 1'b0;
    wr_idx  = dp_idx_reg;
    wr_data = 32'h0000_0000;
    if (wr_pend_reg) begin
      wr_en   = (32'(dp_idx_reg) < DEPTH);
      wr_data = ramg_merge(mem_reg[dp_idx_reg], hwdata, dp_strb_reg);
    end else if (dma_wr_en) begin
      wr_en   = (32'(dma_idx) < DEPTH);
      wr_idx  = dma_idx;
      wr_data = dma_cur.wdata;
    end
  end

  // Registers the RAM write.
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_reg[wr_idx] <= wr_data;
    end
  end

  // Bus data phase: read data, wait states and the two-cycle error.
  always_comb begin
    dp_st_next    = DP_IDLE;
    wait_cnt_next = 1'b0;
    wr_pend_next  = 1'b0;
    dp_idx_next   = dp_idx_reg;
    dp_strb_next  = dp_strb_reg;
    hrdata_next   = hrdata_reg;
    hready_next   = 1'b1;
    hresp_next    = 1'b0;
    case (dp_st_reg)
      DP_WAIT: begin
        if (wait_cnt_reg) begin
          dp_st_next    = DP_WAIT;
          hready_next   = 1'b0;
        end
      end
      DP_ERR1: begin
        dp_st_next = DP_ERR2;
        hresp_next = 1'b1;
      end
      default: begin
        if (acc && cpu_block) begin
          dp_st_next  = DP_ERR1;
          hready_next = 1'b0;
          hresp_next  = 1'b1;
        end else if (acc) begin
          dp_idx_next  = cpu_idx;
          dp_strb_next = ramg_strb(hsize, haddr[1:0]);
          wr_pend_next = hwrite;
          if (!hwrite) begin
            if (32'(cpu_idx) >= DEPTH) begin
              hrdata_next = 32'h0000_0000;
            end else if (wr_pend_reg && dp_idx_reg == cpu_idx) begin
              hrdata_next = ramg_merge(mem_reg[cpu_idx], hwdata,
                                       dp_strb_reg);
            end else begin
              hrdata_next = mem_reg[cpu_idx];
            end
          end
          if (fast_clk_mode) begin
            dp_st_next    = DP_WAIT;
            wait_cnt_next = 1'(WAIT_FAST - 1);
            hready_next   = 1'b0;
          end
        end
      end
    endcase
  end

  // Registers the bus data-phase state.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_st_reg    <= DP_IDLE;
      wait_cnt_reg <= 1'b0;
      wr_pend_reg  <= 1'b0;
      dp_idx_reg   <= '0;
      dp_strb_reg  <= 4'h0;
      hrdata_reg   <= 32'h0000_0000;
      hready_reg   <= 1'b1;
      hresp_reg    <= 1'b0;
    end else begin
      dp_st_reg    <= dp_st_next;
      wait_cnt_reg <= wait_cnt_next;
      wr_pend_reg  <= wr_pend_next;
      dp_idx_reg   <= dp_idx_next;
      dp_strb_reg  <= dp_strb_next;
      hrdata_reg   <= hrdata_next;
      hready_reg   <= hready_next;
      hresp_reg    <= hresp_next;
    end
  end

  // DMA answer and fault capture; a new fault wins over a clear.
  always_comb begin
    gnt_next   = dma_sel;
    drd_next   = drd_reg;
    irq_next   = irq_reg && !fault_clr;
    fault_next = fault_reg;
    if (dma_go && !dma_cur.write) begin
      drd_next = (32'(dma_idx) < DEPTH) ? mem_reg[dma_idx] : 32'h0000_0000;
    end
    if (dma_fault) begin
      irq_next        = 1'b1;
      fault_next.addr = dma_cur.addr;
      fault_next.id   = dma_id;
    end
  end

  // Registers the DMA answer and fault state.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gnt_reg        <= '0;
      drd_reg        <= 32'h0000_0000;
      irq_reg        <= 1'b0;
      fault_reg.addr <= FAULT_ADDR_RST;
      fault_reg.id   <= FAULT_ID_RST;
    end else begin
      gnt_reg   <= gnt_next;
      drd_reg   <= drd_next;
      irq_reg   <= irq_next;
      fault_reg <= fault_next;
    end
  end

  // Outputs straight from their flip-flops.
  assign hrdata     = hrdata_reg;
  assign hreadyout  = hready_reg;
  assign hresp      = hresp_reg;
  assign dma_gnt    = gnt_reg;
  assign dma_rdata  = drd_reg;
  assign fault_irq  = irq_reg;
  assign fault_info = fault_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_user_wr_err: assert property (acc && cpu_block |=>
    hresp_reg && !hready_reg ##1 hresp_reg && hready_reg)
    else $error("Protected user write did not end in a two-cycle error");
  a_sys_wr_ok: assert property (acc && hwrite && hprot[1] |=>
    !hresp_reg && wr_pend_reg)
    else $error("System write was refused");
  a_read_ok: assert property (acc && !hwrite |=> !hresp_reg)
    else $error("Read was answered with an error");
  a_zero_wait: assert property (acc && !cpu_block && !fast_clk_mode |=>
    hready_reg)
    else $error("Normal mode access was stretched");
  a_fast_wait: assert property (acc && !cpu_block && fast_clk_mode |=>
    !hready_reg ##1 !hready_reg ##1 hready_reg)
    else $error("Fast mode access did not get exactly two wait states");
  a_blk_nowrite: assert property (acc && cpu_block |=>
    !wr_pend_reg ##1 !wr_pend_reg)
    else $error("Refused write reached the RAM");
  a_dma_fault: assert property (dma_fault |=> irq_reg &&
    fault_reg.addr == $past(dma_cur.addr) && fault_reg.id == $past(dma_id))
    else $error("DMA fault not captured with the interrupt");
  a_ro_no_irq: assert property (dma_go && !CH_WR_CAP[dma_id] &&
    !irq_reg |=> !irq_reg)
    else $error("Read-only channel raised the protection interrupt");
  a_chk_off: assert property (dma_go && !dma_chk_en && !irq_reg |=>
    !irq_reg)
    else $error("Interrupt raised with DMA checking disabled");
  a_dma_grant: assert property (dma_go |=> gnt_reg == $past(dma_sel) &&
    $onehot(gnt_reg))
    else $error("DMA grant does not match the arbiter choice");

  c_user_err: cover property (acc && cpu_block ##3 acc);
  c_fast_read: cover property (acc && !hwrite && fast_clk_mode ##3 hready_reg);
  c_dma_fault: cover property (irq_reg && fault_clr);
  c_dma_contend: cover property (dma_go && wr_pend_reg == 1'b0 &&
    $countones(dma_req_vld) > 1);

endmodule

// >>> test/ramg_dma_model.sv
// Behavioural model of the six peripheral DMA requesters.
`timescale 1ns/10ps
module ramg_dma_model
  import ramg_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic [NUM_CH-1:0]     dma_gnt,
  output logic      [NUM_CH-1:0]     vld,
  output ramg_dma_req_t [NUM_CH-1:0] req
);
  // Nothing is requested until the bench posts a transfer.
  initial begin
    vld = '0;
    req = '0;
  end

  // Posts one request; the bench calls it at a falling edge.
  task automatic post(input int ch, input ramg_dma_req_t r);
    vld[ch] <= 1'b1;
    req[ch] <= r;
  endtask

  // A granted channel drops its request and scrambles the released fields.
  always @(negedge ref_clk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (dma_gnt[i] === 1'b1) begin
        vld[i] <= 1'b0;
        req[i] <= ~req[i];
      end
    end
  end
endmodule

// >>> test/testbench.sv
// Self-checking bench for the RAM port, its arbiter and write guard.
`timescale 1ns/10ps
module testbench import ramg_pkg::*;;
  typedef struct packed {
    logic        w;
    logic [13:0] off;
    logic [2:0]  sz;
    logic        pr;
    logic [31:0] wd;
    logic        xe;
  } ramg_row_t;

  logic                       ref_clk = 1'b0;
  logic                       srst = 1'b1;
  logic                       hsel = 1'b0;
  logic [31:0]                haddr = '0;
  logic [1:0]                 htrans = '0;
  logic                       hwrite = 1'b0;
  logic [2:0]                 hsize = '0;
  logic [3:0]                 hprot = '0;
  logic [31:0]                hwdata = '0;
  logic                       hready;
  logic [31:0]                hrdata;
  logic                       hreadyout;
  logic                       hresp;
  logic                       fast_clk_mode = 1'b0;
  logic                       dma_chk_en = 1'b0;
  logic [MAP_BITS-1:0]        prot_map = '0;
  logic [NUM_CH-1:0]          vld;
  ramg_dma_req_t [NUM_CH-1:0] req;
  logic [NUM_CH-1:0]          dma_gnt;
  logic [31:0]                dma_rdata;
  logic                       fault_clr = 1'b0;
  logic                       fault_irq;
  ramg_fault_t                fault_info;
  logic [31:0]                mem [4096];
  logic [NUM_CH-1:0]          gq [$];
  logic [31:0]                rq [$];
  int                         n_mismatch = 0;
  int                         samples_checked = 0;
  logic [13:0]                doff [6] = '{14'h0000, 14'h0004, 14'h0100,
                                           14'h0140, 14'h00FC, 14'h3FFC};
  ramg_row_t                  rows [14] = '{
    '{1'b1, 14'h0000, 3'h2, 1'b1, 32'h1122_3344, 1'b0},
    '{1'b1, 14'h0004, 3'h2, 1'b0, 32'hA5A5_A5A5, 1'b0},
    '{1'b1, 14'h0005, 3'h0, 1'b0, 32'h0000_EE00, 1'b0},
    '{1'b1, 14'h0006, 3'h1, 1'b0, 32'hBEEF_0000, 1'b0},
    '{1'b1, 14'h0100, 3'h2, 1'b1, 32'hCAFE_F00D, 1'b0},
    '{1'b1, 14'h0100, 3'h2, 1'b0, 32'hDEAD_BEEF, 1'b1},
    '{1'b1, 14'h0102, 3'h1, 1'b0, 32'h7777_7777, 1'b1},
    '{1'b1, 14'h0140, 3'h2, 1'b0, 32'h0BAD_C0DE, 1'b0},
    '{1'b1, 14'h00FC, 3'h2, 1'b0, 32'h1234_5678, 1'b0},
    '{1'b1, 14'h3FFC, 3'h2, 1'b1, 32'h55AA_55AA, 1'b0},
    '{1'b1, 14'h3FFC, 3'h0, 1'b0, 32'h0000_0099, 1'b1},
    '{1'b1, 14'h3FBC, 3'h2, 1'b0, 32'h6666_6666, 1'b0},
    '{1'b1, 14'h0200, 3'h2, 1'b1, 32'h8765_4321, 1'b0},
    '{1'b1, 14'h0240, 3'h2, 1'b1, 32'h0101_0101, 1'b0}};

  // Single slave on the bus, so its own ready closes the loop.
  assign hready = hreadyout;

  // The clock toggles every half period of 2 ns.
  always #2 ref_clk = ~ref_clk;

  ramg_ram_port #(.RAM_KB(16)) dut (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_clk_mode(fast_clk_mode),
    .dma_chk_en(dma_chk_en), .prot_map(prot_map), .dma_req_vld(vld),
    .dma_req(req), .dma_gnt(dma_gnt), .dma_rdata(dma_rdata),
    .fault_clr(fault_clr), .fault_irq(fault_irq), .fault_info(fault_info));

  ramg_dma_model dma_mdl (.ref_clk(ref_clk), .dma_gnt(dma_gnt),
                          .vld(vld), .req(req));

  // Grants are logged just after the edge that raises them.
  always @(posedge ref_clk) begin
    #1;
    if (dma_gnt !== '0 && srst === 1'b0) begin
      gq.push_back(dma_gnt);
      rq.push_back(dma_rdata);
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares a word-sized result.
  task automatic cmp_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compares a single flag.
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Byte lanes of an access, little endian.
  function automatic logic [31:0] lanes(input logic [2:0] sz,
                                        input logic [1:0] a);
    case (sz)
      3'h0:    return 32'h0000_00FF << (8 * a);
      3'h1:    return a[1] ? 32'hFFFF_0000 : 32'h0000_FFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction

  // Outputs that reset must force.
  task automatic rst_chk();
    cmp_flag("hreadyout", 1'b1, hreadyout);
    cmp_flag("hresp", 1'b0, hresp);
    cmp_flag("fault_irq", 1'b0, fault_irq);
    cmp_word("dma_gnt", 32'h0, 32'(dma_gnt));
    cmp_word("fault_addr", FAULT_ADDR_RST, fault_info.addr);
    cmp_word("fault_id", 32'(FAULT_ID_RST), 32'(fault_info.id));
    cmp_word("hrdata", 32'h0, hrdata);
    cmp_word("dma_rdata", 32'h0, dma_rdata);
  endtask

  // Runs one bus transfer; checks response, wait states and read data.
  task automatic xfer(input logic w, input logic [13:0] off,
                      input logic [2:0] sz, input logic pr,
                      input logic [31:0] wd, input logic xe, input int xw);
    logic        e;
    logic [31:0] m;
    int          n;
    m = lanes(sz, off[1:0]);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= RAM_BASE + {18'h0, off};
    hwrite <= w;
    hsize  <= sz;
    hprot  <= {2'h0, pr, 1'b1};
    @(negedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    e = 1'b0;
    for (n = 0; n < 8 && hreadyout !== 1'b1; n++) begin
      e |= hresp === 1'b1;
      @(negedge ref_clk);
    end
    if (n == 8) begin
      n_mismatch++;
      finish_test();
    end
    e |= hresp === 1'b1;
    cmp_flag("hresp", xe, e);
    cmp_word("waits", 32'(xw), 32'(n));
    if (w && !xe) begin
      mem[off[13:2]] = (mem[off[13:2]] & ~m) | (wd & m);
    end else if (!w) begin
      cmp_word("hrdata", mem[off[13:2]] & m, hrdata & m);
    end
    @(negedge ref_clk);
  endtask

  // Waits a bounded time for the given number of grants.
  task automatic wait_gnt(input int n);
    int k;
    for (k = 0; k < 60 && gq.size() < n; k++) begin
      @(negedge ref_clk);
    end
    if (k == 60) begin
      n_mismatch++;
      finish_test();
    end
  endtask

  // One DMA write, its fault outcome and a read back over the bus.
  task automatic dmaw(input int ch, input logic [13:0] off, input logic chk,
                      input logic [31:0] wd, input logic xf);
    logic [31:0] a;
    a = RAM_BASE + {18'h0, off};
    dma_chk_en <= chk;
    gq.delete();
    dma_mdl.post(ch, '{1'b1, a, wd});
    wait_gnt(1);
    cmp_flag("fault_irq", xf, fault_irq);
    if (xf) begin
      cmp_word("fault_addr", a, fault_info.addr);
      cmp_word("fault_id", 32'(ch), 32'(fault_info.id));
    end else if (CH_WR_CAP[ch]) begin
      mem[off[13:2]] = wd;
    end
    xfer(1'b0, off, 3'h2, 1'b0, 32'h0, 1'b0, 0);
  endtask

  // Main sequence: table of bus cases, then the hand-written cases.
  initial begin
    prot_map[4] = 1'b1;
    prot_map[8] = 1'b1;
    prot_map[255] = 1'b1;
    repeat (20) @(negedge ref_clk);
    rst_chk();
    srst <= 1'b0;
    @(negedge ref_clk);
    for (int i = 0; i < 14; i++) begin
      xfer(rows[i].w, rows[i].off, rows[i].sz, rows[i].pr, rows[i].wd,
           rows[i].xe, rows[i].xe);
      xfer(1'b0, {rows[i].off[13:2], 2'h0}, 3'h2, 1'b0, 32'h0, 1'b0, 0);
    end
    fast_clk_mode <= 1'b1;
    xfer(1'b1, 14'h0008, 3'h2, 1'b1, 32'h0F0F_0F0F, 1'b0, 2);
    xfer(1'b0, 14'h0008, 3'h2, 1'b0, 32'h0, 1'b0, 2);
    fast_clk_mode <= 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      dma_mdl.post(i, '{1'b0, RAM_BASE + {18'h0, doff[i]}, 32'h0});
    end
    wait_gnt(6);
    for (int i = 0; i < NUM_CH; i++) begin
      cmp_word("dma_gnt", 32'(1 << i), 32'(gq[i]));
      cmp_word("dma_rdata", mem[doff[i][13:2]], rq[i]);
    end
    dmaw(4, 14'h0200, 1'b0, 32'hAAAA_0001, 1'b0);
    dmaw(1, 14'h0200, 1'b1, 32'hBBBB_0002, 1'b1);
    fault_clr <= 1'b1;
    @(negedge ref_clk);
    fault_clr <= 1'b0;
    cmp_flag("fault_irq", 1'b0, fault_irq);
    dmaw(2, 14'h0200, 1'b1, 32'hCCCC_0003, 1'b0);
    dmaw(3, 14'h0240, 1'b1, 32'hDDDD_0004, 1'b0);
    xfer(1'b1, 14'h0204, 3'h2, 1'b1, 32'h3C3C_3C3C, 1'b0, 0);
    dmaw(0, 14'h0204, 1'b1, 32'hEEEE_0005, 1'b1);
    srst <= 1'b1;
    repeat (3) @(negedge ref_clk);
    rst_chk();
    srst <= 1'b0;
    @(negedge ref_clk);
    xfer(1'b0, 14'h0240, 3'h2, 1'b0, 32'h0, 1'b0, 0);
    finish_test();
  end
endmodule
